// ==== pkg/efh_pkg.sv ====
/*
  efh_pkg: register map, field layouts, reset values, encodings and timing
  constants for the external feedback hybrid monitor.
  assumes a 40 mhz core clock and an apb slave with 32-bit data.
*/
package efh_pkg;

  // apb register byte offsets
  localparam logic [7:0] EFH_OFS_CTRL     = 8'h00;
  localparam logic [7:0] EFH_OFS_NUM      = 8'h04;
  localparam logic [7:0] EFH_OFS_DEN      = 8'h08;
  localparam logic [7:0] EFH_OFS_LIMIT    = 8'h0c;
  localparam logic [7:0] EFH_OFS_INTERVAL = 8'h10;
  localparam logic [7:0] EFH_OFS_ERR      = 8'h14;
  localparam logic [7:0] EFH_OFS_STATUS   = 8'h18;
  localparam logic [7:0] EFH_OFS_ALARM    = 8'h1c;
  localparam logic [7:0] EFH_OFS_EXTPOS   = 8'h20;

  // ctrl field positions
  localparam int EFH_CTRL_TYPE_LSB = 0;
  localparam int EFH_CTRL_DIR_BIT  = 2;
  localparam int EFH_CTRL_ROT_BIT  = 3;
  localparam int EFH_CTRL_MODE_LSB = 4;

  // alarm bit positions (write one to clear)
  localparam int EFH_ALM_OVF   = 0;
  localparam int EFH_ALM_OSPD  = 1;
  localparam int EFH_ALM_ACCEL = 2;
  localparam int EFH_ALM_TYPE  = 3;

  localparam int EFH_DIV_W = 21;
  localparam int EFH_LIM_W = 28;
  localparam int EFH_ERR_W = 32;
  localparam int EFH_SPD_W = 24;
  localparam int EFH_ACC_W = 48;

  // encodings
  typedef enum logic [1:0]
  {
    EFH_TYPE_QUAD     = 2'b00,
    EFH_TYPE_SERIAL   = 2'b01,
    EFH_TYPE_RESERVED = 2'b10
  } efh_type_t;

  localparam logic [3:0] EFH_MODE_FULL_CLOSED = 4'h6;

  // reset values and the interval maximum
  localparam logic [20:0] EFH_RST_NUM      = 21'h000000;
  localparam logic [20:0] EFH_RST_DEN      = 21'h000001;
  localparam logic [27:0] EFH_RST_LIMIT    = 28'h0010000;
  localparam logic [6:0]  EFH_RST_INTERVAL = 7'h00;
  localparam logic [6:0]  EFH_INTERVAL_MAX = 7'h64;

  // timing: input rates and core clock
  localparam int EFH_CLK_HZ      = 40_000_000;
  localparam int EFH_QUAD_MPPS   = 4;
  localparam int EFH_SERIAL_MPPS = 400;
  // fewest core cycles between quadrature counts, rounded down, at least one
  localparam int EFH_QUAD_MIN_CYC =
    (EFH_CLK_HZ / (EFH_QUAD_MPPS * 1_000_000)) < 1 ? 1 :
    (EFH_CLK_HZ / (EFH_QUAD_MPPS * 1_000_000));

endpackage : efh_pkg

// ==== core/efh_quad_decoder.sv ====
/*
  efh_quad_decoder: x4 decoder for the two-phase external encoder.
  assumes phase inputs are already synchronised to i_core_clk.
*/
`timescale 1ns/1ps
module efh_quad_decoder
  import efh_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_pha,
  input  wire logic i_phb,
  output logic      o_step,
  output logic      o_up,
  output logic      o_illegal
);

  logic [1:0] prev_r;
  logic [1:0] cur;

  assign cur = {i_pha, i_phb};

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      prev_r <= 2'b00;
    else
      prev_r <= cur;
  end

  // gray sequence 00-10-11-01 counts up (a leads b)
  always_comb
  begin
    o_step    = 1'b0;
    o_up      = 1'b0;
    o_illegal = 1'b0;
    if (cur != prev_r)
    begin
      if ((cur ^ prev_r) == 2'b11)
        o_illegal = 1'b1;
      else
      begin
        o_step = 1'b1;
        o_up   = prev_r[0] ^ cur[1];
      end
    end
  end

endmodule : efh_quad_decoder

// ==== core/efh_monitor.sv ====
/*
  efh_monitor: external feedback hybrid monitor with apb register file.
  assumes the serial decoder upstream delivers one-cycle count strobes
  on the core clock, and motor encoder counts arrive as strobes too.
*/
`timescale 1ns/1ps
// Operation
// R1: type 0 quadrature, 1 serial incremental, 2 reserved and flagged.
// R2: direction bit 1 reverses external count direction.
// R3: accept 4 Mpps quadrature after x4, serial rate up to 400 Mpps; serial input here takes one count per core cycle, 40 Mpps at most.
// R4: motor speed above maximum raises overspeed error.
// R5: rotation direction 1 makes counted direction opposite to monitor direction.
// R6: speed command above maximum motor speed raises acceleration error.
// R7: scale external counts by numerator over denominator, 20-bit ranges.
// R8: numerator zero substitutes motor encoder resolution.
// R9: hybrid error is motor position minus scaled external position.
// R10: alarm when hybrid error magnitude exceeds programmed limit.
// R11: clear hybrid error every N motor rotations, zero disables.
// R12: software should not program an extremely small clear interval.
// R13: external path active only in fully-closed mode, value 6.
// R14: signed accumulator wide enough to never wrap before alarm.
module efh_monitor
  import efh_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 i_ext_pha,
  input  wire logic                 i_ext_phb,
  input  wire logic                 i_ser_step,
  input  wire logic                 i_ser_up,
  input  wire logic                 i_mot_step,
  input  wire logic                 i_mot_up,
  input  wire logic [20:0]          i_mot_resolution,
  input  wire logic [EFH_SPD_W-1:0] i_mot_speed,
  input  wire logic [EFH_SPD_W-1:0] i_speed_cmd,
  input  wire logic [EFH_SPD_W-1:0] i_max_speed,
  output logic                      o_hybrid_alarm,
  output logic                      o_overspeed_err,
  output logic                      o_accel_err,
  output logic                      o_ext_active
);

  logic [1:0]  type_r;
  logic        dir_inv_r;
  logic        rot_dir_r;
  logic [3:0]  mode_r;
  logic [20:0] num_r;
  logic [20:0] den_r;
  logic [27:0] limit_r;
  logic [6:0]  interval_r;
  logic [3:0]  alarm_r;
  logic signed [EFH_ERR_W-1:0] err_r;
  logic signed [31:0]          ext_pos_r;
  logic [EFH_ACC_W-1:0]        frac_r;
  logic [20:0]                 rev_cnt_r;
  logic [6:0]                  rot_cnt_r;
  logic [1:0] pha_sync_r;
  logic [1:0] phb_sync_r;

  logic wr_en;
  logic rd_en;
  logic q_step;
  logic q_up;
  logic q_ill;
  logic ext_step;
  logic ext_up;
  logic [20:0] num_eff;
  logic rot_done;
  logic clr_evt;
  logic ovf_evt;
  logic [EFH_ERR_W-1:0] err_mag;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // two flops before the decoder sees the encoder phases
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      pha_sync_r <= 2'b00;
      phb_sync_r <= 2'b00;
    end
    else
    begin
      pha_sync_r <= {pha_sync_r[0], i_ext_pha};
      phb_sync_r <= {phb_sync_r[0], i_ext_phb};
    end
  end

  // at 40 mhz one quadrature edge per 10 cycles fits the 4 mpps budget
  efh_quad_decoder u_quad
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_pha      (pha_sync_r[1]),
    .i_phb      (phb_sync_r[1]),
    .o_step     (q_step),
    .o_up       (q_up),
    .o_illegal  (q_ill)
  ); // R3

  assign o_ext_active = (mode_r == EFH_MODE_FULL_CLOSED); // R13

  // each serial strobe is one count, so serial rate is limited to one count per core clock
  always_comb
  begin
    ext_step = 1'b0;
    ext_up   = 1'b0;
    if (o_ext_active)
    begin
      unique case (efh_type_t'(type_r))
        EFH_TYPE_QUAD:
        begin
          ext_step = q_step; // R1 R3
          ext_up   = q_up;
        end
        EFH_TYPE_SERIAL:
        begin
          ext_step = i_ser_step; // R1 R3
          ext_up   = i_ser_up;
        end
        default:
        begin
          ext_step = 1'b0; // R1
          ext_up   = 1'b0;
        end
      endcase
    end
    ext_up = ext_up ^ dir_inv_r; // R2
  end

  assign num_eff = (num_r == 21'h000000) ? i_mot_resolution : num_r; // R8

  // register writes
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      type_r     <= 2'b00;
      dir_inv_r  <= 1'b0;
      rot_dir_r  <= 1'b0;
      mode_r     <= 4'h0;
      num_r      <= EFH_RST_NUM;
      den_r      <= EFH_RST_DEN;
      limit_r    <= EFH_RST_LIMIT;
      interval_r <= EFH_RST_INTERVAL;
    end
    else if (wr_en)
    begin
      if (hit(paddr, EFH_OFS_CTRL))
      begin
        type_r    <= pwdata[EFH_CTRL_TYPE_LSB +: 2]; // R1
        dir_inv_r <= pwdata[EFH_CTRL_DIR_BIT]; // R2
        rot_dir_r <= pwdata[EFH_CTRL_ROT_BIT];
        mode_r    <= pwdata[EFH_CTRL_MODE_LSB +: 4];
      end
      if (hit(paddr, EFH_OFS_NUM) && pwdata <= 32'h00100000)
        num_r <= pwdata[20:0]; // R7
      if (hit(paddr, EFH_OFS_DEN) && pwdata != 32'h00000000
          && pwdata <= 32'h00100000)
        den_r <= pwdata[20:0]; // R7
      if (hit(paddr, EFH_OFS_LIMIT) && pwdata != 32'h00000000
          && pwdata <= 32'h08000000)
        limit_r <= pwdata[27:0]; // R10
      if (hit(paddr, EFH_OFS_INTERVAL) && pwdata <= 32'(EFH_INTERVAL_MAX))
        interval_r <= pwdata[6:0]; // R11
    end
  end

  // motor rotation counter drives the periodic clear
  assign rot_done = i_mot_step && (rev_cnt_r + 21'h000001 >= i_mot_resolution);
  assign clr_evt  = rot_done && (interval_r != 7'h00)
                    && (rot_cnt_r + 7'h01 >= interval_r); // R11 R12

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || !o_ext_active)
    begin
      rev_cnt_r <= 21'h000000;
      rot_cnt_r <= 7'h00;
    end
    else if (i_mot_step)
    begin
      rev_cnt_r <= rot_done ? 21'h000000 : rev_cnt_r + 21'h000001;
      if (clr_evt)
        rot_cnt_r <= 7'h00;
      else if (rot_done)
        rot_cnt_r <= rot_cnt_r + 7'h01;
    end
  end

  // hybrid error: motor counts minus external counts scaled num/den;
  // fraction kept as remainder so no count is lost to rounding
  always_ff @(posedge i_core_clk)
  begin
    logic signed [EFH_ERR_W-1:0] d;
    logic [EFH_ACC_W-1:0]        f;
    logic [EFH_ACC_W-1:0]        q;
    d = '0;
    f = frac_r;
    q = '0;
    if (i_srst || !o_ext_active)
    begin
      err_r  <= '0;
      frac_r <= '0;
    end
    else
    begin
      if (i_mot_step)
        d = i_mot_up ? 32'sd1 : -32'sd1; // R9
      if (ext_step)
      begin
        f = f + {27'h0000000, num_eff};
        // ratios above one give several units per step; this divider is the slow path
        q = f / {27'h0000000, den_r};
        f = f % {27'h0000000, den_r};
        d = ext_up ? d - signed'(q[EFH_ERR_W-1:0]) : d + signed'(q[EFH_ERR_W-1:0]); // R7 R9
      end
      if (clr_evt)
      begin
        err_r  <= '0; // R11
        frac_r <= '0;
      end
      else
      begin
        err_r  <= err_r + d; // R14
        frac_r <= f;
      end
    end
  end

  // external position monitor shows the monitor direction
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      ext_pos_r <= '0;
    else if (ext_step)
      ext_pos_r <= (ext_up ^ rot_dir_r) ? ext_pos_r + 32'sd1 : ext_pos_r - 32'sd1; // R5
  end

  assign err_mag = err_r[EFH_ERR_W-1] ? 32'(-err_r) : 32'(err_r);
  assign ovf_evt = o_ext_active && (err_mag > {4'h0, limit_r}); // R10

  // sticky alarms: set wins over write-one-to-clear
  always_ff @(posedge i_core_clk)
  begin
    logic [3:0] set_v;
    logic [3:0] clr_v;
    set_v = {(type_r == EFH_TYPE_RESERVED), (i_speed_cmd > i_max_speed),
             (i_mot_speed > i_max_speed), ovf_evt}; // R1 R4 R6 R10
    clr_v = (wr_en && hit(paddr, EFH_OFS_ALARM)) ? pwdata[3:0] : 4'h0;
    if (i_srst)
      alarm_r <= 4'h0;
    else
      alarm_r <= (alarm_r & ~clr_v) | set_v;
  end

  assign o_hybrid_alarm  = alarm_r[EFH_ALM_OVF];
  assign o_overspeed_err = alarm_r[EFH_ALM_OSPD];
  assign o_accel_err     = alarm_r[EFH_ALM_ACCEL];

  always_comb
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      if (hit(paddr, EFH_OFS_CTRL))
        prdata = {24'h000000, mode_r, rot_dir_r, dir_inv_r, type_r};
      if (hit(paddr, EFH_OFS_NUM))
        prdata = {11'h000, num_r};
      if (hit(paddr, EFH_OFS_DEN))
        prdata = {11'h000, den_r};
      if (hit(paddr, EFH_OFS_LIMIT))
        prdata = {4'h0, limit_r};
      if (hit(paddr, EFH_OFS_INTERVAL))
        prdata = {25'h0000000, interval_r};
      if (hit(paddr, EFH_OFS_ERR))
        prdata = err_r;
      if (hit(paddr, EFH_OFS_STATUS))
        prdata = {27'h0000000, q_ill, o_ext_active, 1'b0, rot_cnt_r[1:0]};
      if (hit(paddr, EFH_OFS_ALARM))
        prdata = {28'h0000000, alarm_r};
      if (hit(paddr, EFH_OFS_EXTPOS))
        prdata = ext_pos_r;
    end
  end

  property p_ovf_sets;
    @(posedge i_core_clk) disable iff (i_srst)
    (ovf_evt && !(wr_en && hit(paddr, EFH_OFS_ALARM))) |=> o_hybrid_alarm;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow alarm missed"); // R10
  property p_clear;
    @(posedge i_core_clk) disable iff (i_srst) (clr_evt && o_ext_active) |=> (err_r == 0);
  endproperty
  a_clear: assert property (p_clear) else $error("hybrid error not cleared"); // R11
  property p_inactive;
    @(posedge i_core_clk) disable iff (i_srst) !o_ext_active |=> (err_r == 0);
  endproperty
  a_inactive: assert property (p_inactive) else $error("error moved outside mode 6"); // R13
  property p_ospd;
    @(posedge i_core_clk) disable iff (i_srst) (i_mot_speed > i_max_speed) |=> o_overspeed_err;
  endproperty
  a_ospd: assert property (p_ospd) else $error("overspeed not raised"); // R4
  property p_accel;
    @(posedge i_core_clk) disable iff (i_srst) (i_speed_cmd > i_max_speed) |=> o_accel_err;
  endproperty
  a_accel: assert property (p_accel) else $error("accel error not raised"); // R6
  property p_reserved;
    @(posedge i_core_clk) disable iff (i_srst) (type_r == EFH_TYPE_RESERVED) |-> !ext_step;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved type counted"); // R1
  property p_noclr0;
    @(posedge i_core_clk) disable iff (i_srst) (interval_r == 7'h00) |-> !clr_evt;
  endproperty
  a_noclr0: assert property (p_noclr0) else $error("clear with interval zero"); // R11
  property p_den;
    @(posedge i_core_clk) disable iff (i_srst) den_r != 21'h000000;
  endproperty
  a_den: assert property (p_den) else $error("denominator zero"); // R7

  c_alarm: cover property (@(posedge i_core_clk) $rose(o_hybrid_alarm));
  c_clear: cover property (@(posedge i_core_clk) clr_evt);
  c_serial: cover property (@(posedge i_core_clk) ext_step && type_r == EFH_TYPE_SERIAL);

endmodule : efh_monitor

// ==== verif/efh_enc_model.sv ====
/*
  efh_enc_model: far-side external encoder, quadrature phases or serial strobes.
  assumes the caller steps it from the bench clock process.
*/
`timescale 1ns/1ps
module efh_enc_model
  import efh_pkg::*;
(
  input  wire logic i_core_clk,
  output logic      o_pha,
  output logic      o_phb,
  output logic      o_step,
  output logic      o_up
);
  logic [1:0] ph_r = 2'b00;

  initial
  begin
    o_pha  = 1'b0;
    o_phb  = 1'b0;
    o_step = 1'b0;
    o_up   = 1'b0;
  end

  // up means phase a leads phase b
  task automatic move(input bit ser, input bit up);
    @(posedge i_core_clk);
    if (ser)
    begin
      o_step <= 1'b1;
      o_up   <= up;
      @(posedge i_core_clk);
      o_step <= 1'b0;
      o_up   <= ~up; // qualifier is stale once the strobe is gone
      @(posedge i_core_clk);
    end
    else
    begin
      ph_r = up ? ph_r + 2'd1 : ph_r - 2'd1;
      o_pha <= ph_r[1] ^ ph_r[0];
      o_phb <= ph_r[1];
      repeat (EFH_QUAD_MIN_CYC) @(posedge i_core_clk);
    end
  endtask : move
endmodule : efh_enc_model

// ==== verif/test_external_feedback_hybrid_monitor.sv ====
/*
  bench for efh_monitor: apb master, integer reference model, encoder model.
  assumes zero-wait apb and err updating a cycle after each strobe.
*/
`timescale 1ns/1ps
module test_external_feedback_hybrid_monitor
  import efh_pkg::*;
;
  logic        i_core_clk = 1'b0;
  logic        i_srst     = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0, prdata, q;
  logic        pready, pslverr, pha, phb, sstep, sup, alm, ospd, acc, act;
  logic        mstep = 1'b0, mup = 1'b0;
  logic [20:0] mres = 21'h3;
  logic [23:0] mspd = 24'h0, scmd = 24'h0, smax = 24'h0;
  logic [31:0] seed = 32'd74430;
  int          n_errors = 0, check_count = 0;
  int          err, frac, num, den, ivl, rsteps, extpos, k;
  bit          inv, rot, eo, ea;

  always #12.5 i_core_clk = ~i_core_clk;

  efh_monitor uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_ext_pha(pha), .i_ext_phb(phb), .i_ser_step(sstep), .i_ser_up(sup),
    .i_mot_step(mstep), .i_mot_up(mup), .i_mot_resolution(mres), .i_mot_speed(mspd),
    .i_speed_cmd(scmd), .i_max_speed(smax), .o_hybrid_alarm(alm), .o_overspeed_err(ospd),
    .o_accel_err(acc), .o_ext_active(act));
  efh_enc_model enc (.i_core_clk(i_core_clk), .o_pha(pha), .o_phb(phb), .o_step(sstep),
    .o_up(sup));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : wt

  // request stands until pready is seen high at a rising edge; read data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask : rd

  task automatic rst();
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_srst <= 1'b0;
    {err, frac, rsteps, extpos, num, ivl} = '0;
    den = 1;
  endtask : rst

  task automatic cfg(input logic [31:0] c, input int n, input int d, input int i);
    apb(1'b1, EFH_OFS_CTRL, c);
    apb(1'b1, EFH_OFS_NUM, 32'(n));
    apb(1'b1, EFH_OFS_DEN, 32'(d));
    apb(1'b1, EFH_OFS_INTERVAL, 32'(i));
    {inv, rot} = {c[2], c[3]};
    {num, den, ivl} = {n, d, i};
  endtask : cfg

  task automatic mot(input bit up);
    @(posedge i_core_clk);
    mstep <= 1'b1;
    mup   <= up;
    @(posedge i_core_clk);
    mstep <= 1'b0;
    mup   <= ~up;
    err += up ? 1 : -1;
    rsteps++;
    if (ivl != 0 && rsteps == int'(mres) * ivl)
      {err, frac, rsteps} = '0;
  endtask : mot

  task automatic ext(input bit ser, input bit up);
    bit u;
    u = up ^ inv;
    enc.move(ser, up);
    frac += (num == 0) ? int'(mres) : num;
    while (frac >= den)
    begin
      frac -= den;
      err += u ? -1 : 1;
    end
    extpos += (u ^ rot) ? 1 : -1;
  endtask : ext

  initial
  begin
    #1000000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    logic [7:0]  ofs [4] = '{EFH_OFS_NUM, EFH_OFS_DEN, EFH_OFS_LIMIT, EFH_OFS_INTERVAL};
    logic [31:0] bad [4] = '{32'h200001, 32'h0, 32'h0, 32'h65};
    logic [31:0] ok  [4] = '{32'h100000, 32'h100000, 32'h1, 32'h64};
    logic [31:0] rv  [4] = '{32'(EFH_RST_NUM), 32'(EFH_RST_DEN), 32'(EFH_RST_LIMIT), 32'h0};
    logic [31:0] c, r;
    logic [23:0] a, b, s;
    rst();
    rd(EFH_OFS_CTRL, 32'h0);
    apb(1'b1, 8'h24, 32'hffffffff);
    rd(8'h24, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd(ofs[i], rv[i]);
      apb(1'b1, ofs[i], bad[i]);
      rd(ofs[i], rv[i]);
      apb(1'b1, ofs[i], ok[i]);
      rd(ofs[i], ok[i]);
    end
    $display("test registers done");
    for (int t = 0; t < 2; t++)
    begin
      rst();
      c = t ? 32'h64 : 32'h69;
      cfg(c, t ? 2 : 0, t ? 3 : 2, 0);
      wt(0);
      check(32'(act), 32'h1);
      for (k = 0; k < 24; k++)
      begin
        if (k == 12)
        begin
          rd(EFH_OFS_ERR, 32'(err));
          apb(1'b1, EFH_OFS_CTRL, c ^ 32'h4);
          inv = ~inv;
        end
        r = rnd();
        if (r[0])
          mot(r[1]);
        else
          ext(t == 0, r[2]);
      end
      rd(EFH_OFS_ERR, 32'(err));
      rd(EFH_OFS_EXTPOS, 32'(extpos));
      $display("test feedback type %0d done", 1 - t);
    end
    rst();
    cfg(32'h61, 1, 1, 0);
    apb(1'b1, EFH_OFS_LIMIT, 32'h5);
    for (k = 0; k < 5; k++) mot(1'b1);
    wt(2);
    check(32'(alm), 32'h0);
    mot(1'b1);
    wt(2);
    check(32'(alm), 32'h1);
    rd(EFH_OFS_ALARM, 32'h1);
    for (k = 0; k < 12; k++) ext(1'b1, 1'b1);
    apb(1'b1, EFH_OFS_ALARM, 32'h1);
    wt(1);
    check(32'(alm), 32'h1);
    rd(EFH_OFS_ERR, 32'(err));
    $display("test overflow done");
    rst();
    mres <= 21'h4;
    cfg(32'h61, 1, 1, 2);
    for (k = 0; k < 7; k++) mot(1'b1);
    rd(EFH_OFS_ERR, 32'(err));
    mot(1'b1);
    rd(EFH_OFS_ERR, 32'(err));
    $display("test periodic clear done");
    rst();
    cfg(32'h01, 1, 1, 0);
    for (k = 0; k < 4; k++) mot(1'b1);
    wt(0);
    check(32'(act), 32'h0);
    rd(EFH_OFS_ERR, 32'h0);
    $display("test mode off done");
    rst();
    for (k = 0; k < 10; k++)
    begin
      r = rnd();
      a = r[23:0];
      r = rnd();
      b = r[23:0];
      r = rnd();
      s = r[23:0];
      eo |= b > a;
      ea |= s > a;
      @(posedge i_core_clk);
      smax <= a;
      mspd <= b;
      scmd <= s;
      wt(2);
      check(32'(ospd), 32'(eo));
      check(32'(acc), 32'(ea));
    end
    $display("test speed errors done");
    rst();
    cfg(32'h62, 1, 1, 0);
    rd(EFH_OFS_ALARM, 32'h8 | {29'h0, s > a, b > a, 1'b0});
    $display("test reserved type done");
    complete_run();
  end
endmodule : test_external_feedback_hybrid_monitor
